//--- include/sfcf_pkg.sv
// Shared constants and types for the serial flash command front end
package sfcf_pkg;

  localparam int BYTE_W = 8;
  localparam int ARRAY_ADDR_W = 20;
  localparam int PIN_CNT = 3;

  // Pin positions inside the synchronised pin vector
  localparam int PIN_CS = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 0;
  localparam logic [2:0] PIN_RST = 3'h4;

  // Argument byte counting: three address bytes, index of the last one
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // Supported opcodes
  localparam logic [7:0] OPC_READ_FAST = 8'h0B;
  localparam logic [7:0] OPC_READ_SLOW = 8'h03;
  localparam logic [7:0] OPC_ERASE_4K = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hD8;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_SEQ_PROG_A = 8'hAD;
  localparam logic [7:0] OPC_SEQ_PROG_B = 8'hAF;
  localparam logic [7:0] OPC_WRITE_EN = 8'h06;
  localparam logic [7:0] OPC_WRITE_DIS = 8'h04;
  localparam logic [7:0] OPC_PROT_SECT = 8'h36;
  localparam logic [7:0] OPC_UNPROT_SECT = 8'h39;
  localparam logic [7:0] OPC_READ_PROT = 8'h3C;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_READ_ID = 8'h9F;
  localparam logic [7:0] OPC_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OPC_RESUME = 8'hAB;

  // Command class word: supported, address, dummy, data direction
  localparam int CLS_SUP = 4;
  localparam int CLS_ADDR = 3;
  localparam int CLS_DUMMY = 2;
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_IN = 2'h1;
  localparam logic [1:0] DIR_OUT = 2'h2;

  // Front end states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DATA_IN = 7'h10,
    ST_DATA_OUT = 7'h20,
    ST_IGNORE = 7'h40
  } sfcf_state_t;

endpackage

//--- verilog/sfcf_pin_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module sfcf_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // One pair of flops per pin; only the second stage leaves the module
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        meta_reg[i] <= RST_VAL[i];
        sync_o[i] <= RST_VAL[i];
      end else begin
        meta_reg[i] <= pin_i[i];
        sync_o[i] <= meta_reg[i];
      end
    end
  end

endmodule

//--- verilog/sfcf_shift_in.sv
// Serial input byte assembler, most significant bit first
`timescale 1ns/1ps
module sfcf_shift_in (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic bit_en_i,
  input wire logic bit_i,
  output logic [7:0] byte_o,
  output logic byte_done_o,
  output logic [2:0] bit_cnt_o
);

  logic [6:0] part_reg;

  // Shift each sampled bit in; a deselect drops any partial byte
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      part_reg <= 7'h00;
      bit_cnt_o <= sfcf_pkg::BIT_FIRST;
      byte_o <= 8'h00;
      byte_done_o <= 1'b0;
    end else if (clear_i) begin
      part_reg <= 7'h00;
      bit_cnt_o <= sfcf_pkg::BIT_FIRST;
      byte_done_o <= 1'b0;
    end else begin
      byte_done_o <= bit_en_i && (bit_cnt_o == sfcf_pkg::BIT_LAST);
      if (bit_en_i) begin
        part_reg <= {part_reg[5:0], bit_i};
        bit_cnt_o <= bit_cnt_o + 3'h1;
        if (bit_cnt_o == sfcf_pkg::BIT_LAST) begin
          byte_o <= {part_reg, bit_i};
        end
      end
    end
  end

endmodule

//--- verilog/sfcf_front_end.sv
// Serial flash command front end: framing, opcode decode, arguments, array read
// Behaviour
// - All bytes travel most significant bit first
// - Chip select release ends the operation
// - Unsupported opcode ignored until next select
// - Early release before arguments does nothing
// - Three address bytes, top four bits ignored
// - 0Bh with dummy, 03h without, both read
// - Erases 20h 52h D8h addressed; 60h C7h chip
// - 02h program: address then 1 to 256 bytes (front end passes every byte to the core, no count limit)
// - ADh/AFh sequential program with internal address counter
// - 3Ch reads protection: address then data out
// - 9Fh identification: no address, data out
// - B9h power down, ABh resume, no arguments
// - Read address advances after every byte
// - After arguments, read data shifts out
// - Read wraps from top address to zero
// - Release during read ends it, output off
// - Modes 0 and 3: sample rise, drive fall
`timescale 1ns/1ps
module sfcf_front_end #(
  parameter int ADDR_W = sfcf_pkg::ARRAY_ADDR_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic [7:0] rd_data_i,
  output logic so_o,
  output logic so_oe_o,
  output logic cmd_done_o,
  output logic cmd_aligned_o,
  output logic [7:0] cmd_opcode_o,
  output logic [ADDR_W-1:0] cmd_addr_o,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o,
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic seq_mode_o
);

  // Opcode table: {supported, address bytes, dummy byte, direction}
  function automatic logic [4:0] cmd_class(input logic [7:0] opc);
    case (opc)
      sfcf_pkg::OPC_READ_FAST: cmd_class = {3'b111, sfcf_pkg::DIR_OUT};
      sfcf_pkg::OPC_READ_SLOW: cmd_class = {3'b110, sfcf_pkg::DIR_OUT};
      sfcf_pkg::OPC_ERASE_4K: cmd_class = {3'b110, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_ERASE_32K: cmd_class = {3'b110, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_ERASE_64K: cmd_class = {3'b110, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_CHIP_ERASE_A: cmd_class = {3'b100, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_CHIP_ERASE_B: cmd_class = {3'b100, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_PAGE_PROG: cmd_class = {3'b110, sfcf_pkg::DIR_IN};
      sfcf_pkg::OPC_SEQ_PROG_A: cmd_class = {3'b110, sfcf_pkg::DIR_IN};
      sfcf_pkg::OPC_SEQ_PROG_B: cmd_class = {3'b110, sfcf_pkg::DIR_IN};
      sfcf_pkg::OPC_WRITE_EN: cmd_class = {3'b100, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_WRITE_DIS: cmd_class = {3'b100, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_PROT_SECT: cmd_class = {3'b110, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_UNPROT_SECT: cmd_class = {3'b110, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_READ_PROT: cmd_class = {3'b110, sfcf_pkg::DIR_OUT};
      sfcf_pkg::OPC_READ_STATUS: cmd_class = {3'b100, sfcf_pkg::DIR_OUT};
      sfcf_pkg::OPC_WRITE_STATUS: cmd_class = {3'b100, sfcf_pkg::DIR_IN};
      sfcf_pkg::OPC_READ_ID: cmd_class = {3'b100, sfcf_pkg::DIR_OUT};
      sfcf_pkg::OPC_POWER_DOWN: cmd_class = {3'b100, sfcf_pkg::DIR_NONE};
      sfcf_pkg::OPC_RESUME: cmd_class = {3'b100, sfcf_pkg::DIR_NONE};
      default: cmd_class = {3'b000, sfcf_pkg::DIR_NONE};
    endcase
  endfunction

  // Phase that follows the address bytes, or the opcode when there are none
  function automatic sfcf_pkg::sfcf_state_t after_args(input logic [4:0] cls);
    if (cls[sfcf_pkg::CLS_DUMMY]) begin
      after_args = sfcf_pkg::ST_DUMMY;
    end else if (cls[1:0] == sfcf_pkg::DIR_OUT) begin
      after_args = sfcf_pkg::ST_DATA_OUT;
    end else begin
      after_args = sfcf_pkg::ST_DATA_IN;
    end
  endfunction

  logic [2:0] pins_s;
  logic sck_d_reg;
  logic [7:0] rx_byte;
  logic rx_done;
  logic [2:0] rx_cnt;
  sfcf_pkg::sfcf_state_t state_reg;
  sfcf_pkg::sfcf_state_t state_next;
  logic [7:0] opc_reg;
  logic [15:0] addr_hi_reg;
  logic [1:0] arg_cnt_reg;
  logic [ADDR_W-1:0] seq_addr_reg;
  logic [6:0] out_sh_reg;
  logic [2:0] out_cnt_reg;
  logic data_seen_reg;

  // Pins cross into the system clock through two flops each
  sfcf_pin_sync #(
    .W(sfcf_pkg::PIN_CNT),
    .RST_VAL(sfcf_pkg::PIN_RST)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i({cs_n_i, sck_i, si_i}),
    .sync_o(pins_s)
  );

  // Synchronised pins and serial clock edges
  wire cs_n_s = pins_s[sfcf_pkg::PIN_CS];
  wire sck_s = pins_s[sfcf_pkg::PIN_SCK];
  wire si_s = pins_s[sfcf_pkg::PIN_SI];
  wire sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;

  // Previous serial clock level for edge detection
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
    end
  end

  // Input bytes assembled on rising edges, dropped on deselect
  sfcf_shift_in u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(cs_n_s),
    .bit_en_i(sck_rise),
    .bit_i(si_s),
    .byte_o(rx_byte),
    .byte_done_o(rx_done),
    .bit_cnt_o(rx_cnt)
  );

  // Decode of the incoming opcode and of the held one
  wire [4:0] rx_class = cmd_class(rx_byte);
  wire [4:0] cur_class = cmd_class(opc_reg);
  wire rx_is_seq = (rx_byte == sfcf_pkg::OPC_SEQ_PROG_A) || (rx_byte == sfcf_pkg::OPC_SEQ_PROG_B);
  wire cur_is_seq = (opc_reg == sfcf_pkg::OPC_SEQ_PROG_A) || (opc_reg == sfcf_pkg::OPC_SEQ_PROG_B);
  wire skip_addr = rx_is_seq & seq_mode_o;
  wire need_addr = rx_class[sfcf_pkg::CLS_ADDR] & ~skip_addr;
  wire [23:0] addr_full = {addr_hi_reg, rx_byte};
  wire [ADDR_W-1:0] addr_low = addr_full[ADDR_W-1:0];
  wire addr_last = (state_reg == sfcf_pkg::ST_ADDR) & rx_done & (arg_cnt_reg == sfcf_pkg::ADDR_LAST);
  wire opc_taken = (state_reg == sfcf_pkg::ST_OPCODE) & rx_done;
  wire in_data = (state_reg == sfcf_pkg::ST_DATA_IN) | (state_reg == sfcf_pkg::ST_DATA_OUT);
  wire cmd_end = cs_n_s & in_data;
  wire wr_take = (state_reg == sfcf_pkg::ST_DATA_IN) & rx_done & (cur_class[1:0] == sfcf_pkg::DIR_IN);
  wire byte_load = (state_reg == sfcf_pkg::ST_DATA_OUT) & sck_fall & (out_cnt_reg == sfcf_pkg::BIT_FIRST);
  wire aligned = (rx_cnt == sfcf_pkg::BIT_FIRST) & ((cur_class[1:0] != sfcf_pkg::DIR_IN) | data_seen_reg);

  // Route after the opcode: ignore, address, or straight to data
  sfcf_pkg::sfcf_state_t opc_route;
  assign opc_route = !rx_class[sfcf_pkg::CLS_SUP] ? sfcf_pkg::ST_IGNORE :
                     need_addr ? sfcf_pkg::ST_ADDR : after_args(rx_class);

  // Sequencer; a deselect from any state returns to idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sfcf_pkg::ST_IDLE: begin
        if (!cs_n_s) state_next = sfcf_pkg::ST_OPCODE;
      end
      sfcf_pkg::ST_OPCODE: begin
        if (rx_done) state_next = opc_route;
      end
      sfcf_pkg::ST_ADDR: begin
        if (addr_last) state_next = after_args(cur_class);
      end
      sfcf_pkg::ST_DUMMY: begin
        if (rx_done) state_next = sfcf_pkg::ST_DATA_OUT;
      end
      sfcf_pkg::ST_DATA_IN, sfcf_pkg::ST_DATA_OUT, sfcf_pkg::ST_IGNORE: begin
        state_next = state_reg;
      end
      default: begin
        state_next = sfcf_pkg::ST_IDLE;
      end
    endcase
    if (cs_n_s) state_next = sfcf_pkg::ST_IDLE;
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= sfcf_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Opcode and address capture, most significant byte first
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      opc_reg <= 8'h00;
      addr_hi_reg <= 16'h0000;
      arg_cnt_reg <= 2'h0;
    end else begin
      if (opc_taken) opc_reg <= rx_byte;
      if (state_reg != sfcf_pkg::ST_ADDR) begin
        arg_cnt_reg <= 2'h0;
      end else if (rx_done) begin
        addr_hi_reg <= {addr_hi_reg[7:0], rx_byte};
        arg_cnt_reg <= arg_cnt_reg + 2'h1;
      end
    end
  end

  // Command report to the core; only complete commands are reported
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_done_o <= 1'b0;
      cmd_aligned_o <= 1'b0;
      cmd_opcode_o <= 8'h00;
      cmd_addr_o <= '0;
    end else begin
      cmd_done_o <= cmd_end;
      if (cmd_end) cmd_aligned_o <= aligned;
      if (opc_taken) cmd_opcode_o <= rx_byte;
      if (addr_last) begin
        cmd_addr_o <= addr_low;
      end else if (opc_taken && skip_addr) begin
        cmd_addr_o <= seq_addr_reg;
      end
    end
  end

  // Program data bytes handed to the core one at a time
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_data_o <= 8'h00;
      data_seen_reg <= 1'b0;
    end else begin
      wr_valid_o <= wr_take;
      if (wr_take) wr_data_o <= rx_byte;
      if (state_reg == sfcf_pkg::ST_IDLE) begin
        data_seen_reg <= 1'b0;
      end else if (wr_take) begin
        data_seen_reg <= 1'b1;
      end
    end
  end

  // Sequential program mode flag and its address counter
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seq_mode_o <= 1'b0;
      seq_addr_reg <= '0;
    end else if (cmd_end && cur_is_seq && aligned) begin
      seq_mode_o <= 1'b1;
      seq_addr_reg <= cmd_addr_o + 1'b1;
    end else if (cmd_end && opc_reg == sfcf_pkg::OPC_WRITE_DIS) begin
      seq_mode_o <= 1'b0;
    end
  end

  // Read address: set by the arguments, advanced per byte, wraps at the top
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_addr_o <= '0;
    end else if (addr_last) begin
      rd_addr_o <= addr_low;
    end else if (opc_taken) begin
      rd_addr_o <= '0;
    end else if (byte_load) begin
      rd_addr_o <= rd_addr_o + 1'b1;
    end
  end

  // Serial output: load on the first falling edge of a byte, then shift
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      out_sh_reg <= 7'h00;
      out_cnt_reg <= sfcf_pkg::BIT_FIRST;
    end else begin
      so_oe_o <= (state_reg == sfcf_pkg::ST_DATA_OUT) & ~cs_n_s;
      if (state_reg != sfcf_pkg::ST_DATA_OUT) begin
        out_cnt_reg <= sfcf_pkg::BIT_FIRST;
      end else if (sck_fall) begin
        out_cnt_reg <= out_cnt_reg + 3'h1;
        if (byte_load) begin
          so_o <= rd_data_i[7];
          out_sh_reg <= rd_data_i[6:0];
        end else begin
          so_o <= out_sh_reg[6];
          out_sh_reg <= {out_sh_reg[5:0], 1'b0};
        end
      end
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  cs_release_idle_a: assert property (
    cs_n_s |=> state_reg == sfcf_pkg::ST_IDLE)
    else $error("state not idle after deselect");

  so_release_off_a: assert property (
    (cs_n_s && state_reg == sfcf_pkg::ST_DATA_OUT) |=> !so_oe_o)
    else $error("serial output still driven after deselect");

  ignore_holds_a: assert property (
    (state_reg == sfcf_pkg::ST_IGNORE && !cs_n_s) |=> state_reg == sfcf_pkg::ST_IGNORE
      && !wr_valid_o && !so_oe_o)
    else $error("ignored command produced activity");

  early_release_a: assert property (
    (cs_n_s && (state_reg == sfcf_pkg::ST_OPCODE || state_reg == sfcf_pkg::ST_ADDR
      || state_reg == sfcf_pkg::ST_DUMMY)) |=> !cmd_done_o)
    else $error("incomplete command reported");

  fast_dummy_a: assert property (
    (addr_last && !cs_n_s && opc_reg == sfcf_pkg::OPC_READ_FAST)
      |=> state_reg == sfcf_pkg::ST_DUMMY)
    else $error("fast read skipped its dummy byte");

  slow_read_a: assert property (
    (addr_last && !cs_n_s && opc_reg == sfcf_pkg::OPC_READ_SLOW)
      |=> state_reg == sfcf_pkg::ST_DATA_OUT && rd_addr_o == $past(addr_low))
    else $error("slow read did not start at its address");

  chip_erase_a: assert property (
    (opc_taken && !cs_n_s && (rx_byte == sfcf_pkg::OPC_CHIP_ERASE_A
      || rx_byte == sfcf_pkg::OPC_CHIP_ERASE_B)) |=> state_reg == sfcf_pkg::ST_DATA_IN)
    else $error("chip erase expected address bytes");

  read_advance_a: assert property (
    byte_load |=> rd_addr_o == $past(rd_addr_o) + 1'b1 && so_o == $past(rd_data_i[7]))
    else $error("read address or first bit wrong after byte load");

  read_wrap_a: assert property (
    (byte_load && &rd_addr_o) |=> rd_addr_o == '0)
    else $error("read address failed to wrap");

  prog_data_a: assert property (
    wr_take |=> wr_valid_o && wr_data_o == $past(rx_byte) ##1 !wr_valid_o)
    else $error("program data byte not handed over once");

  unknown_opc_a: assert property (
    (opc_taken && !cs_n_s && !rx_class[sfcf_pkg::CLS_SUP])
      |=> state_reg == sfcf_pkg::ST_IGNORE)
    else $error("unknown opcode not ignored");

  fast_read_c: cover property (state_reg == sfcf_pkg::ST_DUMMY ##[1:300] byte_load);
  ignore_c: cover property (state_reg == sfcf_pkg::ST_IGNORE ##[1:300] cs_n_s);
  seq_entry_c: cover property (!seq_mode_o ##1 seq_mode_o);
  wrap_c: cover property (byte_load && &rd_addr_o);

endmodule

//--- verif/sfcf_spi_master.sv
// Behavioural SPI master that drives the serial pins of the front end
`timescale 1ns/1ps
module sfcf_spi_master #(
  parameter int HALF = 6
) (
  input wire logic clk_sys_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  logic idle_hi;

  // Pins start deselected with the clock parked low
  initial begin
    idle_hi = 1'b0;
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  // A released data line toggles so no stale bit can be mistaken for data
  always @(negedge clk_sys_i) begin
    if (cs_n_o) begin
      si_o <= ~si_o;
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Select the device; mode 3 parks the clock high between frames
  task automatic start(input logic mode3);
    idle_hi = mode3;
    sck_o <= mode3;
    wait_clk(HALF);
    cs_n_o <= 1'b0;
    wait_clk(HALF);
  endtask

  // Shift n bits MSB first: data set while low, answer taken at the rise
  task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck_o <= 1'b0;
      si_o <= tx[i];
      wait_clk(HALF);
      sck_o <= 1'b1;
      rx[i] = so_i;
      wait_clk(HALF);
    end
  endtask

  // Deselect; mode 0 brings the clock low first
  task automatic stop();
    if (!idle_hi) begin
      sck_o <= 1'b0;
    end
    wait_clk(HALF);
    cs_n_o <= 1'b1;
    wait_clk(HALF);
  endtask
endmodule

//--- verif/sfcf_front_end_test.sv
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
module sfcf_front_end_test;
  logic clk_sys_i, rst_i, cs_n, sck, si, so, so_oe, cmd_done, cmd_aligned, wr_valid, seq_mode;
  logic [7:0] rd_data, cmd_opcode, wr_data, u, b;
  logic [19:0] cmd_addr, rd_addr;
  logic [23:0] a;
  logic oe_seen;
  int n_fail = 0;
  int total_checks = 0;
  int n_done;
  integer seed = 32'hc754;
  logic [7:0] wr_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] known[20] = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h60, 8'hC7, 8'h06, 8'hB9,
    8'hAB, 8'h0B, 8'h03, 8'h02, 8'hAD, 8'hAF, 8'h3C, 8'h05, 8'h01, 8'h9F, 8'h04};

  sfcf_front_end u_sfcf_front_end (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .rd_data_i(rd_data), .so_o(so), .so_oe_o(so_oe),
    .cmd_done_o(cmd_done), .cmd_aligned_o(cmd_aligned), .cmd_opcode_o(cmd_opcode),
    .cmd_addr_o(cmd_addr), .wr_valid_o(wr_valid), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
    .seq_mode_o(seq_mode));
  // A released output line shows the inverse of its last bit to the master
  sfcf_spi_master u_sfcf_spi_master (.clk_sys_i(clk_sys_i), .so_i(so_oe ? so : ~so), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));

  // System clock, 8 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [7:0] mem(input logic [19:0] ad);
    return ad[7:0] ^ {ad[11:8], ad[19:16]} ^ 8'hA5;
  endfunction

  // Core array answers half a clock after the pointer moves, on the next falling system clock edge
  always @(negedge clk_sys_i) rd_data <= mem(rd_addr);

  // Monitor of completions, written bytes and output enable, sampled mid-cycle
  always @(negedge clk_sys_i) begin
    if (cmd_done === 1'b1) n_done++;
    if (wr_valid === 1'b1) wr_q.push_back(wr_data);
    if (so_oe === 1'b1) oe_seen = 1'b1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One framed command: opcode, optional address, bytes out, bytes read, partial tail
  task automatic op(input logic m3, input logic [7:0] opc, input logic na,
    input int nw, input int nr, input int tail);
    n_done = 0;
    oe_seen = 1'b0;
    wr_q.delete();
    tx_q.delete();
    rx_q.delete();
    u_sfcf_spi_master.start(m3);
    u_sfcf_spi_master.xbits(opc, 8, b);
    for (int i = 2; i >= 0 && na; i--) u_sfcf_spi_master.xbits(a[i*8 +: 8], 8, b);
    repeat (nw) begin
      tx_q.push_back(8'($random(seed)));
      u_sfcf_spi_master.xbits(tx_q[$], 8, b);
    end
    repeat (nr) begin
      u_sfcf_spi_master.xbits(8'($random(seed)), 8, b);
      rx_q.push_back(b);
    end
    if (tail > 0) u_sfcf_spi_master.xbits(8'($random(seed)), tail, b);
    u_sfcf_spi_master.stop();
  endtask

  // Read command and compare the stream with the array contents
  task automatic rd(input logic m3, input logic [7:0] opc, input int n);
    logic na;
    logic [19:0] s;
    na = (opc != 8'h9F) && (opc != 8'h05);
    s = na ? a[19:0] : 20'h0_0000;
    op(m3, opc, na, (opc == 8'h0B), n, 0);
    chk("read done", 32'h1, n_done);
    chk("read opcode", opc, cmd_opcode);
    if (na) chk("address", a[19:0], cmd_addr);
    for (int i = 0; i < n; i++) chk("read data", mem(s + 20'(i)), rx_q[i]);
  endtask

  task automatic wchk();
    chk("write count", tx_q.size(), wr_q.size());
    foreach (tx_q[i]) chk("write data", tx_q[i], wr_q[i]);
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, about two and a half times the expected run
  initial begin
    #400_000;
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    rd_data = 8'h00;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    repeat (6) begin
      a = 24'($random(seed));
      rd(1'($random(seed)), ($random(seed) & 1) ? 8'h0B : 8'h03, 1 + ($random(seed) & 3));
    end
    a = 24'hAF_FFFE;
    rd(1'b0, 8'h0B, 4);
    a = 24'($random(seed));
    rd(1'b1, 8'h3C, 2);
    rd(1'b0, 8'h9F, 4);
    rd(1'b1, 8'h05, 2);
    op(1'b0, 8'h03, 1'b1, 0, 1, 3);
    chk("oe in read", 32'h1, oe_seen);
    chk("oe after release", 32'h0, so_oe);
    for (int k = 0; k < 10; k++) begin
      op(1'b0, known[k], k < 5, 0, 0, 0);
      chk("no data done", 32'h1, n_done);
      chk("no data opcode", known[k], cmd_opcode);
      u = 8'($random(seed));
      while (u inside {known}) u = 8'($random(seed));
      op(1'b0, u, 1'b1, 2, 0, 0);
      chk("unknown done", 32'h0, n_done);
      chk("unknown writes", 32'h0, wr_q.size());
      chk("unknown oe", 32'h0, oe_seen);
    end
    op(1'b0, 8'h20, 1'b0, 2, 0, 0);
    chk("early release", 32'h0, n_done);
    op(1'b0, 8'h02, 1'b1, 3, 0, 0);
    wchk();
    chk("aligned", 32'h1, cmd_aligned);
    op(1'b0, 8'h02, 1'b1, 1, 0, 3);
    chk("misaligned", 32'h0, cmd_aligned);
    op(1'b0, 8'h01, 1'b0, 1, 0, 0);
    wchk();
    op(1'b0, 8'hAD, 1'b1, 1, 0, 0);
    chk("seq mode on", 32'h1, seq_mode);
    chk("seq address", a[19:0], cmd_addr);
    op(1'b1, 8'hAF, 1'b0, 1, 0, 0);
    wchk();
    chk("seq next", a[19:0] + 20'h0_0001, cmd_addr);
    op(1'b0, 8'h04, 1'b0, 0, 0, 0);
    chk("seq mode off", 32'h0, seq_mode);
    final_report();
  end
endmodule
